// *** verification/can_frame_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// Protocol layer stand-in: takes an offered frame after a set delay, then
// reports completion a fixed number of cycles later.
module can_frame_partner #(
    parameter int FRAME_CYC = 6,
    parameter logic [4:0] ERR_CODE = 5'h13
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_frame_req,
    input wire logic i_fail,
    input wire logic [7:0] i_wait,
    output logic o_accept,
    output logic o_done,
    output logic o_ok,
    output logic [4:0] o_err
);
    logic [7:0] cnt_q;
    logic busy_q;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 8'h00;
            busy_q <= 1'b0;
            o_accept <= 1'b0;
            o_done <= 1'b0;
            o_ok <= 1'b0;
            o_err <= 5'h00;
        end else begin
            o_accept <= 1'b0;
            o_done <= 1'b0;
            // Outside a done pulse the qualifiers carry no meaning, so they
            // keep changing rather than holding a stale value.
            o_ok <= ~o_ok;
            o_err <= ~o_err;
            if (busy_q) begin
                cnt_q <= cnt_q + 8'h01;
                // An accepted frame completes even if its request is dropped.
                if (cnt_q == FRAME_CYC[7:0]) begin
                    o_done <= 1'b1;
                    o_ok <= ~i_fail;
                    o_err <= ERR_CODE;
                    busy_q <= 1'b0;
                    cnt_q <= 8'h00;
                end
            end else if (i_frame_req && !o_accept) begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q >= i_wait) begin
                    o_accept <= 1'b1;
                    busy_q <= 1'b1;
                    cnt_q <= 8'h00;
                end
            end else begin
                cnt_q <= 8'h00;
            end
        end
    end
endmodule // can_frame_partner
`default_nettype wire

// *** verification/can_message_buffer_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "can_seq_consts.svh"
module can_message_buffer_sequencer_tb_top;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, freq, frtr, fail = 1'b0;
    logic [3:0] fbuf, flen;
    logic [28:0] fid;
    logic [7:0] pwait = 8'h00;
    wire logic acc, done, ok;
    wire logic [4:0] err;
    int failures = 0, samples_checked = 0, cycles = 0;
    always #4 clk = ~clk;
    can_msg_seq dut_u (.i_core_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_frame_req(freq), .o_frame_buf(fbuf),
        .o_frame_id(fid), .o_frame_len(flen), .o_frame_rtr(frtr),
        .i_frame_accept(acc), .i_frame_done(done), .i_frame_ok(ok),
        .i_err_code(err));
    can_frame_partner #(.FRAME_CYC(6), .ERR_CODE(5'h13)) peer_u (
        .i_core_clk(clk), .i_rst(rst), .i_frame_req(freq), .i_fail(fail),
        .i_wait(pwait), .o_accept(acc), .o_done(done), .o_ok(ok), .o_err(err));
    task automatic final_report();
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; result and error are taken at the completing edge.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] mask,
        input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r & mask, exp);
    endtask
    function automatic logic [11:0] ba(input logic [3:0] m,
        input logic [1:0] w);
        return `ADDR_BUF_BASE + {4'h0, m, w, 2'b00};
    endfunction
    task automatic setup_buf(input logic [3:0] m, input logic [31:0] conf);
        wr(ba(m, `BUF_W_CTRL), 32'h0000_0000);
        wr(ba(m, `BUF_W_CONF), conf);
        wr(ba(m, `BUF_W_LEN), 32'h0000_0008);
        wr(ba(m, `BUF_W_ID), 32'h1234_5678);
        wr(ba(m, `BUF_W_CTRL), 32'h0000_0001);
    endtask
    task automatic wait_req();
        int n;
        n = 0;
        while (freq !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic wait_quiet();
        int n;
        n = 0;
        while ((freq !== 1'b0 || dut_idle() == 1'b0) && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, freq}, 32'h0000_0000);
    endtask
    function automatic logic dut_idle();
        return peer_u.busy_q === 1'b0;
    endfunction
    task automatic t_reset_and_modes();
        logic [31:0] r;
        logic e;
        rd_chk(`ADDR_MODULE_CTRL, 32'hFFFF_FFFF, 32'h0000_0500);
        rd_chk(`ADDR_ERR_CNT, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 12'h0F0, 32'h0000_0000, r, e);
        chk({31'h0, e}, 32'h0000_0001);
        chk(r, 32'h0000_0000);
        for (int m = 0; m < 6; m++) begin
            wr(`ADDR_MODULE_CTRL, m);
            rd_chk(`ADDR_MODULE_CTRL, 32'h0000_0007, m);
        end
        wr(`ADDR_MODULE_CTRL, 32'h0000_0006);
        rd_chk(`ADDR_MODULE_CTRL, 32'h0000_0007, 32'h0000_0005);
    endtask
    // A receive-type buffer below the transmit buffer must be passed over.
    task automatic t_normal_tx();
        wr(`ADDR_MODULE_CTRL, 32'h0000_0000);
        setup_buf(4'h3, 32'h0000_0003);
        setup_buf(4'h9, 32'h0000_0011);
        wr(`ADDR_MODULE_CTRL, 32'h0000_0001);
        wr(ba(4'h3, `BUF_W_CTRL), 32'h0000_0003);
        wr(ba(4'h9, `BUF_W_CTRL), 32'h0000_0003);
        wait_req();
        chk({28'h0, fbuf}, 32'h0000_0009);
        chk({3'h0, fid}, 32'h1234_5678);
        chk({28'h0, flen}, 32'h0000_0008);
        chk({31'h0, frtr}, 32'h0000_0001);
        wait_quiet();
        rd_chk(ba(4'h9, `BUF_W_CTRL), 32'h0000_0007, 32'h0000_0001);
        rd_chk(`ADDR_LAST_TX, 32'h0000_000F, 32'h0000_0009);
        rd_chk(`ADDR_TX_HIST, 32'h0000_010F, 32'h0000_0009);
        rd_chk(`ADDR_TX_HIST, 32'h0000_0100, 32'h0000_0100);
    endtask
    task automatic t_abort();
        pwait <= 8'd40;
        wr(ba(4'h9, `BUF_W_CTRL), 32'h0000_0003);
        wait_req();
        wr(ba(4'h9, `BUF_W_CTRL), 32'h0000_0001);
        wait_quiet();
        rd_chk(`ADDR_TX_HIST, 32'h0000_0100, 32'h0000_0100);
        pwait <= 8'd0;
        wr(ba(4'h9, `BUF_W_CTRL), 32'h0000_0003);
        wait_req();
        while (freq === 1'b1) @(posedge clk);
        wr(ba(4'h9, `BUF_W_CTRL), 32'h0000_0001);
        wait_quiet();
        rd_chk(`ADDR_TX_HIST, 32'h0000_010F, 32'h0000_0009);
    endtask
    task automatic t_block();
        wr(`ADDR_MODULE_CTRL, 32'h0000_0002);
        setup_buf(4'h0, 32'h0000_0001);
        setup_buf(4'h2, 32'h0000_0001);
        wr(ba(4'h0, `BUF_W_CTRL), 32'h0000_0003);
        wr(ba(4'h2, `BUF_W_CTRL), 32'h0000_0003);
        rd_chk(`ADDR_MODULE_CTRL, 32'h0000_0200, 32'h0000_0000);
        wr(`ADDR_MODULE_CTRL, 32'h0001_0002);
        wait_req();
        chk({28'h0, fbuf}, 32'h0000_0000);
        wait_quiet();
        wait_req();
        chk({28'h0, fbuf}, 32'h0000_0002);
        wait_quiet();
        repeat (20) @(posedge clk);
        rd_chk(`ADDR_MODULE_CTRL, 32'h0001_0207, 32'h0000_0002);
        rd_chk(`ADDR_TX_HIST, 32'h0000_010F, 32'h0000_0000);
        rd_chk(`ADDR_TX_HIST, 32'h0000_010F, 32'h0000_0002);
    endtask
    task automatic t_errors();
        wr(`ADDR_MODULE_CTRL, 32'h0000_0004);
        setup_buf(4'hA, 32'h0000_0001);
        fail <= 1'b1;
        wr(ba(4'hA, `BUF_W_CTRL), 32'h0000_0003);
        wait_req();
        wait_quiet();
        fail <= 1'b0;
        rd_chk(ba(4'hA, `BUF_W_CTRL), 32'h0000_0003, 32'h0000_0001);
        rd_chk(`ADDR_ERR_CNT, 32'h0000_00FF, 32'h0000_0001);
        rd_chk(`ADDR_ERR_DETAIL, 32'h0000_001F, 32'h0000_0013);
        wr(`ADDR_MODULE_CTRL, 32'h0000_0000);
        wr(ba(4'hA, `BUF_W_CTRL), 32'h0000_0000);
        wr(`ADDR_MODULE_CTRL, 32'h0000_0008);
        rd_chk(`ADDR_ERR_CNT, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk(`ADDR_ERR_DETAIL, 32'hFFFF_FFFF, 32'h0000_0000);
    endtask
    // Nine sends with no history reads overfill the eight-entry list.
    task automatic t_hist_overflow();
        wr(ba(4'h9, `BUF_W_CTRL), 32'h0000_0001);
        wr(`ADDR_MODULE_CTRL, 32'h0000_0001);
        for (int k = 0; k < 9; k++) begin
            wr(ba(4'h9, `BUF_W_CTRL), 32'h0000_0003);
            wait_req();
            wait_quiet();
        end
        rd_chk(`ADDR_TX_HIST, 32'h0000_0200, 32'h0000_0200);
        rd_chk(`ADDR_TX_HIST, 32'h0000_0200, 32'h0000_0200);
        wr(`ADDR_TX_HIST, 32'h0000_0200);
        rd_chk(`ADDR_TX_HIST, 32'h0000_0200, 32'h0000_0000);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_and_modes();
        t_normal_tx();
        t_abort();
        t_block();
        t_errors();
        t_hist_overflow();
        final_report();
    end
endmodule // can_message_buffer_sequencer_tb_top
`default_nettype wire

// *** verilog/can_msg_seq.sv ***
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "can_seq_consts.svh"
// Functional notes
// - Modes: normal, block transmit, receive-only, single-shot, self-test, plus init.
// - Clear-error bit written in init resets error counter and error detail.
// - Type field 000 marks transmit, 001 to 101 marks receive.
// - Block transmission serves buffers 0 to 7 only.
// - History overflow flag is sticky; host then scans buffers.
// - A request accepted by the protocol layer still transmits after clearing.
module can_msg_seq #(
    parameter int NBUF = 16,
    parameter int HIST_DEPTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_frame_req,
    output logic [3:0] o_frame_buf,
    output logic [28:0] o_frame_id,
    output logic [3:0] o_frame_len,
    output logic o_frame_rtr,
    input wire logic i_frame_accept,
    input wire logic i_frame_done,
    input wire logic i_frame_ok,
    input wire logic [4:0] i_err_code
);
    initial begin
        if (NBUF != 16 || HIST_DEPTH < 2 || HIST_DEPTH > 16) begin
            $error("can_msg_seq: unsupported NBUF or HIST_DEPTH");
        end
    end

    localparam int HW = $clog2(HIST_DEPTH);

    can_seq_pkg::op_mode_e mode_q;
    can_seq_pkg::tx_state_e st_q;
    logic [NBUF-1:0] rdy_q, trq_q, nd_q, asg_q, rtr_q;
    logic [2:0] typ_q [NBUF];
    logic [3:0] len_q [NBUF];
    logic [28:0] id_q [NBUF];
    logic [7:0] err_cnt_q;
    logic [4:0] err_det_q;
    logic abt_trg_q, acc_en_q, ovf_q, cur_abt_q;
    logic [2:0] abt_ptr_q;
    logic [3:0] cur_q, last_q;
    logic [3:0] hist_q [HIST_DEPTH];
    logic [HW-1:0] hwr_q, hrd_q;
    logic [HW:0] hcnt_q;
    logic [31:0] rdata_q;
    logic wr, rd_acc, setup, a_buf, mapped;
    logic [3:0] a_idx;
    logic [1:0] a_word;
    logic [NBUF-1:0] txable;
    logic norm_hit, blk_hit, pick_abt, done_ok, hist_pop, hist_push;
    logic [3:0] norm_idx, pick_idx, blk_idx;

    assign wr = i_psel && i_penable && i_pwrite;
    assign rd_acc = i_psel && i_penable && !i_pwrite;
    assign setup = i_psel && !i_penable;
    assign a_buf = i_paddr[11:8] == 4'h1;
    assign a_idx = i_paddr[7:4];
    assign a_word = i_paddr[3:2];
    // Zero wait states; read data is captured in the setup cycle.
    assign o_pready = 1'b1;
    assign o_prdata = rdata_q;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign blk_idx = {1'b0, abt_ptr_q};

    always_comb begin
        if (a_buf && i_paddr[1:0] == 2'b00) begin
            mapped = 1'b1;
        end else if (i_paddr == `ADDR_MODULE_CTRL ||
                     i_paddr == `ADDR_ERR_CNT ||
                     i_paddr == `ADDR_ERR_DETAIL ||
                     i_paddr == `ADDR_TX_HIST ||
                     i_paddr == `ADDR_LAST_TX) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Candidate buffers and lowest-index selection for ordinary sends.
    always_comb begin
        norm_hit = 1'b0;
        norm_idx = 4'h0;
        for (int m = 0; m < NBUF; m++) begin
            txable[m] = rdy_q[m] && trq_q[m] && asg_q[m] &&
                        typ_q[m] == `BUF_TYPE_TX;
        end
        for (int m = NBUF - 1; m >= 0; m--) begin
            // In block mode buffers 0..7 belong to the block sequence.
            if (txable[m] && !(mode_q == can_seq_pkg::MODE_ABT &&
                               m <= 7)) begin
                norm_hit = 1'b1;
                norm_idx = 4'(m);
            end
        end
    end
    assign blk_hit = mode_q == can_seq_pkg::MODE_ABT && abt_trg_q &&
                     txable[blk_idx];
    assign pick_abt = blk_hit;
    assign pick_idx = blk_hit ? blk_idx : norm_idx;
    assign done_ok = st_q == can_seq_pkg::TX_BUSY && i_frame_done &&
                     i_frame_ok;

    // Protocol-layer hand-off.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= can_seq_pkg::TX_IDLE;
            cur_q <= 4'h0;
            cur_abt_q <= 1'b0;
        end else begin
            case (st_q)
                can_seq_pkg::TX_IDLE: begin
                    if (mode_q != can_seq_pkg::MODE_INIT &&
                        mode_q != can_seq_pkg::MODE_RX_ONLY &&
                        (blk_hit || norm_hit)) begin
                        st_q <= can_seq_pkg::TX_REQ;
                        cur_q <= pick_idx;
                        cur_abt_q <= pick_abt;
                    end
                end
                can_seq_pkg::TX_REQ: begin
                    // Until accepted, a cleared request withdraws the frame.
                    if (!trq_q[cur_q]) begin
                        st_q <= can_seq_pkg::TX_IDLE;
                    end else if (i_frame_accept) begin
                        st_q <= can_seq_pkg::TX_BUSY;
                    end
                end
                can_seq_pkg::TX_BUSY: begin
                    // Once accepted the frame runs to its end.
                    if (i_frame_done) begin
                        st_q <= can_seq_pkg::TX_IDLE;
                    end
                end
                default: st_q <= can_seq_pkg::TX_IDLE;
            endcase
        end
    end
    assign o_frame_req = st_q == can_seq_pkg::TX_REQ;
    assign o_frame_buf = cur_q;
    assign o_frame_id = id_q[cur_q];
    assign o_frame_len = len_q[cur_q];
    assign o_frame_rtr = rtr_q[cur_q];

    // Module control, block trigger and pointer.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= can_seq_pkg::MODE_INIT;
            abt_trg_q <= 1'b0;
            abt_ptr_q <= 3'h0;
            acc_en_q <= 1'b0;
        end else begin
            acc_en_q <= 1'b1;
            if (wr && i_paddr == `ADDR_MODULE_CTRL) begin
                if (i_pwdata[`MC_MODE_LSB +: 3] <= 3'h5) begin
                    mode_q <= can_seq_pkg::op_mode_e'(
                        i_pwdata[`MC_MODE_LSB +: 3]);
                end
                abt_trg_q <= i_pwdata[`MC_ABT_TRG] &&
                             mode_q == can_seq_pkg::MODE_ABT;
                if (i_pwdata[`MC_ABT_CLR]) begin
                    abt_ptr_q <= 3'h0;
                end
            end else if (abt_trg_q && st_q == can_seq_pkg::TX_IDLE &&
                         !txable[blk_idx]) begin
                // Skip buffers with nothing to send; end after the last.
                abt_ptr_q <= abt_ptr_q + 3'h1;
                if (blk_idx == `ABT_LAST_BUF) begin
                    abt_trg_q <= 1'b0;
                end
            end else if (done_ok && cur_abt_q) begin
                abt_ptr_q <= abt_ptr_q + 3'h1;
                if (cur_q == `ABT_LAST_BUF) begin
                    abt_trg_q <= 1'b0;
                end
            end
        end
    end

    // Error counter and detail.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            err_cnt_q <= 8'h00;
            err_det_q <= 5'h00;
        end else if (wr && i_paddr == `ADDR_MODULE_CTRL &&
                     i_pwdata[`MC_CLR_ERR] &&
                     mode_q == can_seq_pkg::MODE_INIT) begin
            err_cnt_q <= 8'h00;
            err_det_q <= 5'h00;
        end else if (st_q == can_seq_pkg::TX_BUSY && i_frame_done &&
                     !i_frame_ok) begin
            err_cnt_q <= err_cnt_q + {7'h00, err_cnt_q != 8'hFF};
            err_det_q <= i_err_code;
        end
    end

    // Message buffers.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdy_q <= '0;
            trq_q <= '0;
            nd_q <= '0;
            asg_q <= '0;
            rtr_q <= '0;
            for (int m = 0; m < NBUF; m++) begin
                typ_q[m] <= 3'h0;
                len_q[m] <= 4'h0;
                id_q[m] <= 29'h0000_0000;
            end
        end else begin
            // A finished frame releases its request; single-shot also
            // drops it after a failed attempt.
            if (st_q == can_seq_pkg::TX_BUSY && i_frame_done &&
                (i_frame_ok || mode_q == can_seq_pkg::MODE_SINGLE)) begin
                trq_q[cur_q] <= 1'b0;
            end
            if (wr && a_buf) begin
                if (a_word == `BUF_W_CTRL) begin
                    rdy_q[a_idx] <= i_pwdata[`BC_READY];
                    trq_q[a_idx] <= i_pwdata[`BC_TRQ];
                    nd_q[a_idx] <= i_pwdata[`BC_NEW_DATA];
                end else if (a_word == `BUF_W_CONF) begin
                    asg_q[a_idx] <= i_pwdata[`BF_ASSIGNED];
                    typ_q[a_idx] <= i_pwdata[`BF_TYPE_LSB +: 3];
                    rtr_q[a_idx] <= i_pwdata[`BF_RTR];
                end else if (a_word == `BUF_W_LEN) begin
                    len_q[a_idx] <= i_pwdata[3:0];
                end else begin
                    id_q[a_idx] <= i_pwdata[28:0];
                end
            end
        end
    end

    // Transmit history list; a push into a full list with no pop in the same cycle sets overflow.
    assign hist_push = done_ok;
    assign hist_pop = rd_acc && i_paddr == `ADDR_TX_HIST && hcnt_q != '0;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hwr_q <= '0;
            hrd_q <= '0;
            hcnt_q <= '0;
            ovf_q <= 1'b0;
            last_q <= 4'h0;
            for (int k = 0; k < HIST_DEPTH; k++) begin
                hist_q[k] <= 4'h0;
            end
        end else begin
            if (hist_push) begin
                last_q <= cur_q;
            end
            if (hist_push && (hcnt_q != (HW+1)'(HIST_DEPTH) || hist_pop)) begin
                hist_q[hwr_q] <= cur_q;
                hwr_q <= HW'((32'(hwr_q) + 1) % HIST_DEPTH);
            end
            if (hist_pop) begin
                hrd_q <= HW'((32'(hrd_q) + 1) % HIST_DEPTH);
            end
            if (hist_push && !hist_pop &&
                hcnt_q != (HW+1)'(HIST_DEPTH)) begin
                hcnt_q <= hcnt_q + 1'b1;
            end else if (hist_pop && !hist_push) begin
                hcnt_q <= hcnt_q - 1'b1;
            end
            // Setting wins over a clear in the same cycle.
            if (hist_push && !hist_pop &&
                hcnt_q == (HW+1)'(HIST_DEPTH)) begin
                ovf_q <= 1'b1;
            end else if (wr && i_paddr == `ADDR_TX_HIST &&
                         i_pwdata[`TH_OVF]) begin
                ovf_q <= 1'b0;
            end
        end
    end

    // Read data captured during the setup cycle.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup && !i_pwrite) begin
            rdata_q <= 32'h0000_0000;
            if (a_buf) begin
                if (a_word == `BUF_W_CTRL) begin
                    rdata_q[2:0] <= {nd_q[a_idx], trq_q[a_idx],
                                     rdy_q[a_idx]};
                end else if (a_word == `BUF_W_CONF) begin
                    rdata_q[4:0] <= {rtr_q[a_idx], typ_q[a_idx],
                                     asg_q[a_idx]};
                end else if (a_word == `BUF_W_LEN) begin
                    rdata_q[3:0] <= len_q[a_idx];
                end else begin
                    rdata_q[28:0] <= id_q[a_idx];
                end
            end else if (i_paddr == `ADDR_MODULE_CTRL) begin
                rdata_q[2:0] <= mode_q;
                rdata_q[`MC_INIT_ST] <= mode_q == can_seq_pkg::MODE_INIT;
                rdata_q[`MC_TX_BUSY] <= st_q != can_seq_pkg::TX_IDLE;
                rdata_q[`MC_ACC_EN] <= acc_en_q;
                rdata_q[`MC_ABT_TRG] <= abt_trg_q;
            end else if (i_paddr == `ADDR_ERR_CNT) begin
                rdata_q[7:0] <= err_cnt_q;
            end else if (i_paddr == `ADDR_ERR_DETAIL) begin
                rdata_q[4:0] <= err_det_q;
            end else if (i_paddr == `ADDR_TX_HIST) begin
                rdata_q[3:0] <= hist_q[hrd_q];
                rdata_q[`TH_EMPTY] <= hcnt_q == '0;
                rdata_q[`TH_OVF] <= ovf_q;
            end else if (i_paddr == `ADDR_LAST_TX) begin
                rdata_q[3:0] <= last_q;
            end
        end
    end

    sequence s_taken;
        o_frame_req && i_frame_accept && trq_q[cur_q];
    endsequence
    sequence s_finished;
        st_q == can_seq_pkg::TX_BUSY && i_frame_done && i_frame_ok;
    endsequence

    frame_type_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_frame_req |-> typ_q[cur_q] == `BUF_TYPE_TX)
        else $error("frame from non-transmit buffer");
    no_tx_init_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (mode_q == can_seq_pkg::MODE_INIT ||
         mode_q == can_seq_pkg::MODE_RX_ONLY) &&
        st_q == can_seq_pkg::TX_IDLE |=> !o_frame_req)
        else $error("transmit started in init or receive-only mode");
    block_range_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_frame_req && cur_abt_q |-> cur_q <= `ABT_LAST_BUF)
        else $error("block transmit outside buffers 0 to 7");
    accepted_runs_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_taken ##1 !i_frame_done |=> st_q == can_seq_pkg::TX_BUSY)
        else $error("accepted frame dropped before done");
    abort_req_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_frame_req && !trq_q[cur_q] |=> !o_frame_req)
        else $error("cleared request not withdrawn");
    done_release_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_finished |=> !trq_q[$past(cur_q)] && last_q == $past(cur_q))
        else $error("finished frame keeps its request");
    err_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        wr && i_paddr == `ADDR_MODULE_CTRL && i_pwdata[`MC_CLR_ERR] &&
        mode_q == can_seq_pkg::MODE_INIT |=> err_cnt_q == 8'h00 &&
        err_det_q == 5'h00)
        else $error("error registers not cleared");
    ovf_sticky_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ovf_q && !(wr && i_paddr == `ADDR_TX_HIST) |=> ovf_q)
        else $error("history overflow dropped without clear");
endmodule // can_msg_seq
`default_nettype wire

// *** verilog/can_seq_consts.svh ***
`ifndef CAN_SEQ_CONSTS_SVH
`define CAN_SEQ_CONSTS_SVH
// Register byte addresses.
`define ADDR_MODULE_CTRL 12'h000
`define ADDR_ERR_CNT 12'h004
`define ADDR_ERR_DETAIL 12'h008
`define ADDR_TX_HIST 12'h00C
`define ADDR_LAST_TX 12'h010
`define ADDR_BUF_BASE 12'h100
// Buffer stride is 16 bytes; word select within a buffer.
`define BUF_W_CTRL 2'h0
`define BUF_W_CONF 2'h1
`define BUF_W_LEN 2'h2
`define BUF_W_ID 2'h3
// Module control fields.
`define MC_MODE_LSB 0
`define MC_CLR_ERR 3
`define MC_INIT_ST 8
`define MC_TX_BUSY 9
`define MC_ACC_EN 10
`define MC_ABT_TRG 16
`define MC_ABT_CLR 17
// Buffer control and config fields.
`define BC_READY 0
`define BC_TRQ 1
`define BC_NEW_DATA 2
`define BF_ASSIGNED 0
`define BF_TYPE_LSB 1
`define BF_RTR 4
`define BUF_TYPE_TX 3'h0
// History register fields.
`define TH_EMPTY 8
`define TH_OVF 9
// Block transmission covers buffers 0 up to this index.
`define ABT_LAST_BUF 4'h7
`endif

// *** verilog/can_seq_pkg.sv ***
package can_seq_pkg;
    typedef enum logic [2:0] {
        MODE_INIT = 3'b000,
        MODE_NORMAL = 3'b001,
        MODE_ABT = 3'b010,
        MODE_RX_ONLY = 3'b011,
        MODE_SINGLE = 3'b100,
        MODE_SELF_TEST = 3'b101
    } op_mode_e;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_REQ = 2'b01,
        TX_BUSY = 2'b10
    } tx_state_e;
endpackage
